/* serial_access_defines.svh */
// constants for the serial register access link
`ifndef SERIAL_ACCESS_DEFINES_SVH
`define SERIAL_ACCESS_DEFINES_SVH
`define START_PATTERN 4'hC
`define FRAME_EDGES 6'h20
`define POS_OPCODE_END 6'h05
`define POS_ID_END 6'h0D
`define POS_INDEX_END 6'h15
`define POS_GAP 6'h16
`define POS_DATA_END 6'h1E
`define POS_LAST 6'h1F
`define READ_FIRST 6'h17
`define DIVIDE_HALF 4'h4
`define ID_RESET 6'h00
`endif

/* serial_access_pkg.sv */
// types shared by both ends of the serial register access link
package serial_access_pkg;
    typedef enum logic [1:0] {
        single_write_op = 2'b00,
        broadcast_write_op = 2'b01,
        single_read_op = 2'b10,
        forced_read_op = 2'b11
    } opcode_e;
    typedef enum logic [1:0] {
        ST_HUNT = 2'b00,
        ST_BODY = 2'b01
    } link_state_e;
endpackage

/* serial_access_if.sv */
// link wires between controller and memory device
`timescale 1ns/1ns
interface serial_access_if;
    logic serial_clk;
    logic reset_pin;
    logic command_line;
    logic chain_input_pin;
    logic chain_output_pin;
    logic chain_output_oe;
    modport device (input serial_clk, input reset_pin, input command_line,
        input chain_input_pin, output chain_output_pin, output chain_output_oe);
    modport controller (output serial_clk, output reset_pin, output command_line,
        output chain_input_pin, input chain_output_pin, input chain_output_oe);
endinterface

/* serial_device.sv */
// device end: serial register access slave clocked by the link clock, with a system clock side
`timescale 1ns/1ns
`include "serial_access_defines.svh"
module serial_device #(
    parameter int NUM_REGS = 256
) (
    serial_access_if.device LINK,
    input wire logic SYS_CLK,
    input wire logic NRST,
    output logic [7:0] REG_INDEX,
    output logic [7:0] REG_WDATA,
    output logic REG_WRITE,
    input wire logic [7:0] REG_RDATA,
    output logic [5:0] DEVICE_ID
);
    import serial_access_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // link domain: everything on the falling serial clock except the read word capture on the rising edge
    link_state_e state;
    logic [3:0] hunt;
    logic [5:0] count;
    logic [7:0] shreg;
    logic [1:0] opcode_field;
    logic [5:0] id_field;
    logic [7:0] register_index_field;
    logic [7:0] rbyte;
    logic [5:0] device_identifier;
    logic drive_data;
    logic forward;
    logic out_bit;
    logic oe;
    logic wr_toggle;
    logic [7:0] wr_index;
    logic [7:0] wr_data;
    logic [7:0] sync_rd0;
    logic rd_toggle;

    wire [3:0] next_hunt = {hunt[2:0], LINK.command_line};
    wire start_seen = next_hunt == `START_PATTERN;
    wire id_match = id_field == device_identifier;
    wire is_read = opcode_field[1];
    wire selected = opcode_field[0] | id_match;
    // count is the frame position of the bit being sampled: 0..3 start, 4..5 opcode,
    // 6..7 pad, 8..13 identifier, 14..21 index, 22 gap, 23..30 data, 31 last
    wire in_read = count >= `READ_FIRST && count < `POS_DATA_END;

    // frame sequencer; reset pin resets the link logic only at clock edges
    always_ff @(negedge LINK.serial_clk) begin
        if (LINK.reset_pin) begin
            state <= ST_HUNT;
            hunt <= 4'h0;
            count <= 6'h00;
        end else if (state == ST_HUNT) begin
            hunt <= next_hunt;
            count <= 6'h04;
            if (start_seen) begin
                state <= ST_BODY;
                hunt <= 4'h0;
            end
        end else begin
            count <= count + 6'h01;
            if (count == `POS_LAST) begin
                state <= ST_HUNT;
            end
        end
    end

    // field capture, msb first
    always_ff @(negedge LINK.serial_clk) begin
        shreg <= {shreg[6:0], LINK.command_line};
        if (state == ST_BODY && count == `POS_OPCODE_END) begin
            opcode_field <= {shreg[0], LINK.command_line};
        end
        if (state == ST_BODY && count == `POS_ID_END) begin
            id_field <= {shreg[4:0], LINK.command_line};
        end
        if (state == ST_BODY && count == `POS_INDEX_END) begin
            register_index_field <= {shreg[6:0], LINK.command_line};
        end
    end

    // write commit at last data bit; crosses to system side by toggle
    always_ff @(negedge LINK.serial_clk) begin
        if (LINK.reset_pin) begin
            wr_toggle <= 1'b0;
            wr_index <= 8'h00;
            wr_data <= 8'h00;
            device_identifier <= `ID_RESET;
        end else if (state == ST_BODY && count == `POS_DATA_END && !is_read
                && selected) begin
            wr_toggle <= ~wr_toggle;
            wr_index <= register_index_field;
            wr_data <= {shreg[6:0], LINK.command_line};
            if (register_index_field == 8'h01) begin
                device_identifier <= {shreg[4:0], LINK.command_line};
            end
        end
    end

    // read request: the index is complete at the end of its field; the toggle
    // tells the system side to present that register before the gap bit ends
    always_ff @(negedge LINK.serial_clk) begin
        if (LINK.reset_pin) begin
            rd_toggle <= 1'b0;
        end else if (state == ST_BODY && count == `POS_INDEX_END && is_read) begin
            rd_toggle <= ~rd_toggle;
        end
    end

    // read word taken on the rising link edge inside the gap bit, then again
    // into the shifter on the falling edge that ends it; the system side holds
    // it still from a few clocks after the index lands to the end of the frame,
    // so the link half period must exceed about three system clocks
    always_ff @(posedge LINK.serial_clk) begin
        sync_rd0 <= REG_RDATA;
    end

    // read output: load at gap bit, shift msb first at counts 23..29, driving bits 23..30
    always_ff @(negedge LINK.serial_clk) begin
        if (LINK.reset_pin) begin
            drive_data <= 1'b0;
            forward <= 1'b0;
            rbyte <= 8'h00;
        end else if (state == ST_BODY && count == `POS_GAP && is_read) begin
            drive_data <= selected;
            forward <= !selected;
            rbyte <= register_index_field == 8'h01 ? {2'b00, device_identifier}
                : sync_rd0;
        end else if (in_read) begin
            rbyte <= {rbyte[6:0], 1'b0};
        end else begin
            drive_data <= 1'b0;
            forward <= 1'b0;
        end
    end

    // chain output: register bit or pass-through of chain input
    assign out_bit = drive_data ? rbyte[7] : (forward ? LINK.chain_input_pin : 1'b0);
    assign oe = drive_data | forward;
    assign LINK.chain_output_pin = out_bit;
    assign LINK.chain_output_oe = oe;

    ////////////////////////////////////////////////////////////////////////
    // system domain: toggle synchroniser turns a commit into one pulse
    logic [2:0] wr_sync;
    logic [2:0] rd_sync;
    logic [5:0] id_s0;
    logic [5:0] id_s1;

    // one pulse per toggle seen past the second synchroniser flop
    wire write_pulse = wr_sync[2] ^ wr_sync[1];
    wire read_pulse = rd_sync[2] ^ rd_sync[1];

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            wr_sync <= 3'b000;
            rd_sync <= 3'b000;
        end else begin
            wr_sync <= {wr_sync[1:0], wr_toggle};
            rd_sync <= {rd_sync[1:0], rd_toggle};
        end
    end

    // index and data are stable for at least two sys clocks before the toggle lands
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            REG_INDEX <= 8'h00;
            REG_WDATA <= 8'h00;
            REG_WRITE <= 1'b0;
            id_s0 <= `ID_RESET;
            id_s1 <= `ID_RESET;
        end else begin
            REG_WRITE <= write_pulse;
            if (write_pulse) begin
                REG_INDEX <= wr_index;
                REG_WDATA <= wr_data;
            end else if (read_pulse) begin
                REG_INDEX <= register_index_field;
            end
            id_s0 <= device_identifier;
            id_s1 <= id_s0;
        end
    end

    assign DEVICE_ID = id_s1;
endmodule

/* serial_controller.sv */
// controller end: issues 32-edge serial transactions, makes the link clock
`timescale 1ns/1ns
`include "serial_access_defines.svh"
module serial_controller (
    serial_access_if.controller LINK,
    input wire logic SYS_CLK,
    input wire logic NRST,
    input wire logic REQ_VALID,
    output logic REQ_READY,
    input wire serial_access_pkg::opcode_e REQ_OPCODE,
    input wire logic [5:0] REQ_ID,
    input wire logic [7:0] REQ_INDEX,
    input wire logic [7:0] REQ_WDATA,
    input wire logic LINK_RESET,
    input wire logic CHAIN_IN,
    output logic DONE,
    output logic [7:0] READ_DATA
);
    import serial_access_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // divider makes serial clock; bits change on its rising edge, so they stand
    // still around the falling edge at which the device samples them
    logic [3:0] div;
    logic sck;
    logic busy;
    logic [5:0] count;
    logic [31:0] frame;
    logic [7:0] rd;
    logic is_read;
    logic cmd;
    logic rst_pin;
    logic [1:0] sdo_sync;

    wire half = div == `DIVIDE_HALF - 4'h1;
    wire fall = half & sck; // clock about to fall
    wire rise = half & !sck; // clock about to rise: next bit goes out
    wire [31:0] next_frame = {`START_PATTERN, REQ_OPCODE, 2'b00, REQ_ID, REQ_INDEX,
        1'b0, REQ_OPCODE[1] ? 8'h00 : REQ_WDATA, 1'b0};

    assign REQ_READY = !busy && !rst_pin;

    // clock runs only during frames and while the reset pin is high; idle low-high parked high
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            div <= 4'h0;
            sck <= 1'b1;
        end else if (busy || rst_pin) begin
            div <= half ? 4'h0 : div + 4'h1;
            if (half) begin
                sck <= ~sck;
            end
        end else begin
            div <= 4'h0;
            sck <= 1'b1;
        end
    end

    // frame shifter: a new bit at each rising edge, msb first; falls are counted
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            busy <= 1'b0;
            count <= 6'h00;
            frame <= 32'h0;
            cmd <= 1'b0;
            is_read <= 1'b0;
            rst_pin <= 1'b1;
            DONE <= 1'b0;
        end else begin
            DONE <= 1'b0;
            // the reset pin never moves at a falling link edge, where it is sampled
            if (!fall) begin
                rst_pin <= LINK_RESET;
            end
            if (REQ_VALID && REQ_READY) begin
                busy <= 1'b1;
                frame <= {next_frame[30:0], 1'b0};
                cmd <= next_frame[31];
                count <= 6'h00;
                is_read <= REQ_OPCODE[1];
            end else if (busy && rise) begin
                cmd <= frame[31];
                frame <= {frame[30:0], 1'b0};
            end else if (busy && fall) begin
                count <= count + 6'h01;
                if (count == `POS_LAST) begin
                    busy <= 1'b0;
                    cmd <= 1'b0;
                    DONE <= 1'b1;
                end
            end
        end
    end

    // chain output from the device passes two flops before use
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            sdo_sync <= 2'b00;
            rd <= 8'h00;
            READ_DATA <= 8'h00;
        end else begin
            sdo_sync <= {sdo_sync[0], LINK.chain_output_pin};
            if (busy && fall && is_read && count >= `READ_FIRST
                    && count <= `POS_DATA_END) begin
                rd <= {rd[6:0], sdo_sync[1]};
            end
            if (busy && fall && count == `POS_LAST) begin
                READ_DATA <= rd;
            end
        end
    end

    assign LINK.serial_clk = sck;
    assign LINK.reset_pin = rst_pin;
    assign LINK.command_line = cmd;
    assign LINK.chain_input_pin = CHAIN_IN;
endmodule

/* serial_access_checker.sv */
// concurrent checks on the serial register access link wires
`timescale 1ns/1ns
module serial_access_checker (
    input wire logic serial_clk,
    input wire logic reset_pin,
    input wire logic command_line,
    input wire logic chain_output_oe
);
    logic [2:0] hist;
    logic [4:0] pos;
    logic busy;
    logic rd;
    logic forced;
    default clocking cb @(negedge serial_clk); endclocking
    default disable iff (reset_pin);
    ////////////////////////////////////////////////////////////
    // frame tracker: hunts the start pattern, then counts body bits
    always_ff @(negedge serial_clk) begin
        if (reset_pin) begin
            hist <= 3'h0;
            pos <= 5'h00;
            busy <= 1'b0;
            rd <= 1'b0;
            forced <= 1'b0;
        end else if (!busy) begin
            hist <= {hist[1:0], command_line};
            if ({hist, command_line} == 4'hC) begin
                hist <= 3'h0; // cleared so a stale prefix never restarts a frame
                busy <= 1'b1;
                pos <= 5'h04;
            end
        end else begin
            pos <= pos + 5'h01;
            busy <= (pos != 5'h1F);
            if (pos == 5'h04) rd <= command_line;
            if (pos == 5'h05) forced <= rd & command_line;
        end
    end
    property p_pad; busy && (pos == 5'h06 || pos == 5'h07) |-> !command_line; endproperty
    a_pad: assert property (p_pad) else $error("pad bit not zero");
    property p_gap; busy && pos == 5'h16 |-> !command_line; endproperty
    a_gap: assert property (p_gap) else $error("gap bit not zero");
    property p_last; busy && pos == 5'h1F |-> !command_line; endproperty
    a_last: assert property (p_last) else $error("final bit not zero");
    property p_rzero; busy && rd && pos >= 5'h17 && pos <= 5'h1E |-> !command_line; endproperty
    a_rzero: assert property (p_rzero) else $error("read phase command not zero");
    property p_wquiet; busy && !rd && pos >= 5'h06 |-> !chain_output_oe; endproperty
    a_wquiet: assert property (p_wquiet) else $error("output driven in write");
    property p_early; busy && pos >= 5'h06 && pos <= 5'h15 |-> !chain_output_oe; endproperty
    a_early: assert property (p_early) else $error("output driven before gap");
    property p_fdrive; busy && forced && pos >= 5'h17 && pos <= 5'h1E |-> chain_output_oe;
    endproperty
    a_fdrive: assert property (p_fdrive) else $error("forced read not driven");
    property p_release; busy && pos == 5'h1F |-> ##[0:2] !chain_output_oe; endproperty
    a_release: assert property (p_release) else $error("output not released");
endmodule

/* serial_register_access_test.sv */
// testbench: controller and device joined over the link
`timescale 1ns/1ns
module serial_register_access_test;
    import serial_access_pkg::*;
    logic SYS_CLK, NRST, req_valid, req_ready, link_reset, chain_in, done, reg_write;
    opcode_e req_opcode;
    logic [5:0] req_id, device_id;
    logic [7:0] req_index, req_wdata, read_data, reg_index, reg_wdata, reg_rdata;
    logic [7:0] regs [256];
    int mismatches, comparisons, writes;
    serial_access_if link ();
    serial_controller u_serial_controller (.LINK(link.controller), .SYS_CLK(SYS_CLK),
        .NRST(NRST), .REQ_VALID(req_valid), .REQ_READY(req_ready), .REQ_OPCODE(req_opcode),
        .REQ_ID(req_id), .REQ_INDEX(req_index), .REQ_WDATA(req_wdata),
        .LINK_RESET(link_reset), .CHAIN_IN(chain_in), .DONE(done), .READ_DATA(read_data));
    serial_device u_serial_device (.LINK(link.device), .SYS_CLK(SYS_CLK), .NRST(NRST),
        .REG_INDEX(reg_index), .REG_WDATA(reg_wdata), .REG_WRITE(reg_write),
        .REG_RDATA(reg_rdata), .DEVICE_ID(device_id));
    serial_access_checker u_serial_access_checker (.serial_clk(link.serial_clk),
        .reset_pin(link.reset_pin), .command_line(link.command_line),
        .chain_output_oe(link.chain_output_oe));
    ////////////////////////////////////////////////////////////
    // user register file; held still through a read frame
    assign reg_rdata = regs[reg_index];
    always @(posedge SYS_CLK) begin
        if (reg_write === 1'b1) begin
            regs[reg_index] <= reg_wdata;
            writes++;
        end
    end
    initial begin
        SYS_CLK = 1'b0;
        forever #5 SYS_CLK = ~SYS_CLK;
    end
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask
    // one frame through the request handshake, bounded waits
    task automatic xfer(input opcode_e op, input logic [5:0] id, input logic [7:0] idx,
        input logic [7:0] wd);
        int n;
        n = 0;
        @(negedge SYS_CLK);
        req_opcode = op;
        req_id = id;
        req_index = idx;
        req_wdata = wd;
        req_valid = 1'b1;
        while (req_ready !== 1'b1 && n < 4000) begin
            @(negedge SYS_CLK);
            n++;
        end
        @(negedge SYS_CLK);
        req_valid = 1'b0;
        while (done !== 1'b1 && n < 4000) begin
            @(negedge SYS_CLK);
            n++;
        end
        check("done", {7'h00, done}, 8'h01);
        @(negedge SYS_CLK);
    endtask
    task automatic read_check(input opcode_e op, input logic [5:0] id,
        input logic [7:0] idx, input logic [7:0] exp);
        xfer(op, id, idx, 8'h00);
        check("read data", read_data, exp);
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // watchdog: about seventy frames of margin
    initial begin
        repeat (20000) @(posedge SYS_CLK);
        mismatches++;
        summarize();
    end
    initial begin
        NRST = 1'b0;
        req_valid = 1'b0;
        req_opcode = single_write_op;
        req_id = 6'h00;
        req_index = 8'h00;
        req_wdata = 8'h00;
        link_reset = 1'b1;
        chain_in = 1'b0;
        mismatches = 0;
        comparisons = 0;
        writes = 0;
        foreach (regs[i]) regs[i] = 8'h00;
        repeat (20) @(negedge SYS_CLK);
        NRST = 1'b1;
        // link reset needs falling serial edges to land in the device
        repeat (100) @(negedge SYS_CLK);
        link_reset = 1'b0;
        check("identifier", {2'b00, device_id}, 8'h00);
        xfer(single_write_op, 6'h00, 8'h05, 8'hA5);
        check("write count", 8'(writes), 8'h01);
        read_check(single_read_op, 6'h00, 8'h05, 8'hA5);
        xfer(single_write_op, 6'h03, 8'h05, 8'h3C);
        check("write count", 8'(writes), 8'h01);
        xfer(broadcast_write_op, 6'h3F, 8'h01, 8'h2A);
        check("identifier", {2'b00, device_id}, 8'h2A);
        read_check(single_read_op, 6'h2A, 8'h05, 8'hA5);
        chain_in = 1'b1;
        read_check(single_read_op, 6'h00, 8'h05, 8'hFF);
        chain_in = 1'b0;
        read_check(single_read_op, 6'h01, 8'h05, 8'h00);
        xfer(forced_read_op, 6'h00, 8'h01, 8'h00);
        check("identifier read", {2'b00, read_data[5:0]}, 8'h2A);
        xfer(broadcast_write_op, 6'h15, 8'h09, 8'h81);
        read_check(forced_read_op, 6'h15, 8'h09, 8'h81);
        summarize();
    end
endmodule
